/* design/icdn_day_night.v */
// Day/night controller for an infrared-cut filter with an APB register file
`include "icdn_defines.vh"

// Behaviour
// - Auto mode detects night/day changes itself and moves the filter to match.
// - Forced night mode keeps the filter out of the light path.
// - Forced day mode keeps the filter in front of the sensor.
// - Input mode sets the filter from the selected I/O port level.
// - A read-only status shows whether the filter is in night or day position.
// - Threshold and timing govern the filter only in auto mode.
// - Day to night only after darkness stays above level longer than wait.
// - Night to day only after darkness stays below level longer than wait.
// - Darkness reads as a signed level, rising as the scene darkens.
// - One wait time in whole seconds serves both directions.
// - With announce enabled, a selected I/O port shows night or day.
module icdn_day_night #(
    parameter [31:0] SEC_CYCLES = `ICDN_SEC_CYCLES
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    // Darkness measurement
    input wire [15:0] darkLevel,
    // General purpose I/O ports
    input wire [7:0] gpioIn,
    output reg [7:0] gpioOut,
    output reg [7:0] gpioOe,
    // Filter actuator
    output reg filterNight,
    // Interrupt
    output reg irq
);

    localparam [2:0] ST_DAY = 3'b001;
    localparam [2:0] ST_NIGHT = 3'b010;
    localparam [2:0] ST_FORCED = 3'b100;

    // One-hot decode of a three-bit port selector
    function [7:0] portOneHot;
        input [2:0] sel;
        begin
            portOneHot = 8'h01 << sel;
        end
    endfunction

    // Address match against a register offset
    function addrIs;
        input [7:0] addr;
        input [7:0] off;
        begin
            addrIs = (addr == off);
        end
    endfunction

    // Configuration registers
    reg [1:0] mode;
    reg announceEn;
    reg [2:0] inSel;
    reg [2:0] annSel;
    reg [15:0] switchLevel;
    reg [15:0] waitTime;
    reg [2:0] intMask;

    // Status and control state
    reg [2:0] intStat;
    reg [2:0] intReadSnap;
    reg [2:0] autoState;
    reg [2:0] next_autoState;
    reg next_filterNight;
    reg prevAbove;

    // Bus decode
    wire setupPhase;
    wire accessPhase;
    wire wrDone;
    wire rdDone;
    reg mapped;
    reg [31:0] rdValue;

    // Darkness comparison
    wire darkAbove;
    wire darkBelow;
    wire pending;
    wire [15:0] heldSeconds;
    wire heldPartial;
    wire timeUp;
    wire [2:0] events;
    wire [7:0] annHot;

    assign setupPhase = psel && !penable;
    assign accessPhase = psel && penable;
    assign pready = accessPhase;
    assign wrDone = accessPhase && pwrite;
    assign rdDone = accessPhase && !pwrite;

    // Signed comparison of measured darkness with the switch level
    assign darkAbove = $signed(darkLevel) > $signed(switchLevel);
    assign darkBelow = $signed(darkLevel) < $signed(switchLevel);

    // Condition that would move the filter, valid only in auto mode
    assign pending = (mode == `ICDN_MODE_AUTO) &&
                     (((autoState == ST_DAY) && darkAbove) ||
                      ((autoState == ST_NIGHT) && darkBelow));

    // Strictly longer than the wait time, shared by both directions
    assign timeUp = (heldSeconds > waitTime) ||
                    ((heldSeconds == waitTime) && heldPartial);

    // Timer runs only while the crossing persists
    icdn_sec_timer #(
        .SEC_CYCLES(SEC_CYCLES)
    ) uTimer (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(pending),
        .seconds(heldSeconds),
        .partial(heldPartial)
    );

    // Auto state machine and filter position
    always @* begin
        next_autoState = autoState;
        next_filterNight = filterNight;
        case (mode)
            `ICDN_MODE_AUTO: begin
                case (autoState)
                    ST_DAY: begin
                        next_filterNight = 1'b0;
                        if (pending && timeUp) begin
                            next_autoState = ST_NIGHT;
                            next_filterNight = 1'b1;
                        end
                    end
                    ST_NIGHT: begin
                        next_filterNight = 1'b1;
                        if (pending && timeUp) begin
                            next_autoState = ST_DAY;
                            next_filterNight = 1'b0;
                        end
                    end
                    ST_FORCED: begin
                        // Resume auto from the position the filter now holds
                        next_autoState = filterNight ? ST_NIGHT : ST_DAY;
                    end
                    default: begin
                        next_autoState = ST_DAY;
                        next_filterNight = 1'b0;
                    end
                endcase
            end
            `ICDN_MODE_NIGHT: begin
                next_autoState = ST_FORCED;
                next_filterNight = 1'b1;
            end
            `ICDN_MODE_DAY: begin
                next_autoState = ST_FORCED;
                next_filterNight = 1'b0;
            end
            `ICDN_MODE_INPUT: begin
                next_autoState = ST_FORCED;
                // Port direction and function are set up by software
                next_filterNight = gpioIn[inSel];
            end
            default: begin
                next_autoState = ST_FORCED;
                next_filterNight = filterNight;
            end
        endcase
    end

    // Filter state registers
    always @(posedge sys_clk) begin
        if (rst) begin
            autoState <= ST_DAY;
            filterNight <= 1'b0;
            prevAbove <= darkAbove; // Track the level so release brings no false crossing
        end else begin
            autoState <= next_autoState;
            filterNight <= next_filterNight;
            prevAbove <= darkAbove;
        end
    end

    // Events: filter moved to night, to day, darkness crossed the level
    assign events[`ICDN_INT_TO_NIGHT] = next_filterNight && !filterNight;
    assign events[`ICDN_INT_TO_DAY] = !next_filterNight && filterNight;
    assign events[`ICDN_INT_CROSS] = (darkAbove != prevAbove);

    // Announce port drive
    assign annHot = portOneHot(annSel);

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : gAnnounce
            // Each port is driven only when announcing and selected
            always @(posedge sys_clk) begin
                if (rst) begin
                    gpioOut[gi] <= 1'b0;
                    gpioOe[gi] <= 1'b0;
                end else begin
                    gpioOe[gi] <= announceEn && annHot[gi];
                    gpioOut[gi] <= announceEn && annHot[gi] && next_filterNight;
                end
            end
        end
    endgenerate

    // Configuration writes take effect at the completing access edge
    always @(posedge sys_clk) begin
        if (rst) begin
            mode <= `ICDN_MODE_AUTO;
            announceEn <= 1'b0;
            inSel <= 3'h0;
            annSel <= 3'h0;
            switchLevel <= `ICDN_RST_SWLEVEL;
            waitTime <= `ICDN_RST_WAIT;
            intMask <= `ICDN_RST_INTMASK;
        end else if (wrDone) begin
            if (addrIs(paddr, `ICDN_OFF_CTRL)) begin
                mode <= pwdata[`ICDN_CTRL_MODE_MSB:`ICDN_CTRL_MODE_LSB];
                announceEn <= pwdata[`ICDN_CTRL_ANN_EN];
                inSel <= pwdata[`ICDN_CTRL_INSEL_MSB:`ICDN_CTRL_INSEL_LSB];
                annSel <= pwdata[`ICDN_CTRL_ANNSEL_MSB:`ICDN_CTRL_ANNSEL_LSB];
            end
            if (addrIs(paddr, `ICDN_OFF_SWLEVEL)) begin
                switchLevel <= pwdata[15:0];
            end
            if (addrIs(paddr, `ICDN_OFF_WAIT)) begin
                waitTime <= pwdata[15:0];
            end
            if (addrIs(paddr, `ICDN_OFF_INTMASK)) begin
                intMask <= pwdata[`ICDN_INT_WIDTH-1:0];
            end
        end
    end

    // Read multiplexer, sampled in the setup cycle
    always @* begin
        rdValue = 32'h00000000;
        mapped = 1'b1;
        case (paddr)
            `ICDN_OFF_CTRL: begin
                rdValue[`ICDN_CTRL_MODE_MSB:`ICDN_CTRL_MODE_LSB] = mode;
                rdValue[`ICDN_CTRL_ANN_EN] = announceEn;
                rdValue[`ICDN_CTRL_INSEL_MSB:`ICDN_CTRL_INSEL_LSB] = inSel;
                rdValue[`ICDN_CTRL_ANNSEL_MSB:`ICDN_CTRL_ANNSEL_LSB] = annSel;
            end
            `ICDN_OFF_SWLEVEL: begin
                rdValue = {{16{switchLevel[15]}}, switchLevel};
            end
            `ICDN_OFF_WAIT: begin
                rdValue[15:0] = waitTime;
            end
            `ICDN_OFF_CURLEVEL: begin
                rdValue = {{16{darkLevel[15]}}, darkLevel};
            end
            `ICDN_OFF_STATE: begin
                rdValue[`ICDN_ST_NIGHT] = filterNight;
                rdValue[`ICDN_ST_DARK] = darkAbove;
                rdValue[`ICDN_ST_PENDING] = pending;
            end
            `ICDN_OFF_INTSTAT: begin
                rdValue[`ICDN_INT_WIDTH-1:0] = intStat;
            end
            `ICDN_OFF_INTMASK: begin
                rdValue[`ICDN_INT_WIDTH-1:0] = intMask;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Registered read data and error answer
    always @(posedge sys_clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            intReadSnap <= 3'h0;
        end else if (setupPhase) begin
            prdata <= pwrite ? 32'h00000000 : rdValue;
            pslverr <= !mapped;
            intReadSnap <= (!pwrite && addrIs(paddr, `ICDN_OFF_INTSTAT)) ?
                           intStat : 3'h0;
        end
    end

    // Sticky interrupt status; a read clears only the bits it returned
    always @(posedge sys_clk) begin
        if (rst) begin
            intStat <= 3'h0;
        end else if (rdDone && addrIs(paddr, `ICDN_OFF_INTSTAT)) begin
            intStat <= (intStat & ~intReadSnap) | events;
        end else begin
            intStat <= intStat | events;
        end
    end

    // Level interrupt output
    always @(posedge sys_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(intStat & intMask);
        end
    end

endmodule

/* design/icdn_sec_timer.v */
// Persistence timer counting whole seconds while a condition holds
`include "icdn_defines.vh"

module icdn_sec_timer #(
    parameter [31:0] SEC_CYCLES = `ICDN_SEC_CYCLES
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Control
    input wire run,
    // Elapsed time
    output reg [15:0] seconds,
    output reg partial
);

    reg [31:0] cycCount;

    // Count cycles and seconds; a dropped run restarts from zero
    always @(posedge sys_clk) begin
        if (rst || !run) begin
            cycCount <= 32'h00000000;
            seconds <= 16'h0000;
            partial <= 1'b0;
        end else begin
            if (cycCount == SEC_CYCLES - 32'h00000001) begin
                cycCount <= 32'h00000000;
                partial <= 1'b0;
                if (seconds != 16'hffff) begin
                    seconds <= seconds + 16'h0001;
                end
            end else begin
                cycCount <= cycCount + 32'h00000001;
                partial <= 1'b1;
            end
        end
    end

endmodule

/* include/icdn_defines.vh */
// Constants for the infrared-cut day/night controller
`ifndef ICDN_DEFINES_VH
`define ICDN_DEFINES_VH

// Register byte offsets
`define ICDN_OFF_CTRL 8'h00
`define ICDN_OFF_SWLEVEL 8'h04
`define ICDN_OFF_WAIT 8'h08
`define ICDN_OFF_CURLEVEL 8'h0c
`define ICDN_OFF_STATE 8'h10
`define ICDN_OFF_INTSTAT 8'h14
`define ICDN_OFF_INTMASK 8'h18

// Mode codes in the control register
`define ICDN_MODE_AUTO 2'h0
`define ICDN_MODE_NIGHT 2'h1
`define ICDN_MODE_DAY 2'h2
`define ICDN_MODE_INPUT 2'h3

// Control register fields
`define ICDN_CTRL_MODE_LSB 0
`define ICDN_CTRL_MODE_MSB 1
`define ICDN_CTRL_ANN_EN 4
`define ICDN_CTRL_INSEL_LSB 8
`define ICDN_CTRL_INSEL_MSB 10
`define ICDN_CTRL_ANNSEL_LSB 12
`define ICDN_CTRL_ANNSEL_MSB 14

// State register fields
`define ICDN_ST_NIGHT 0
`define ICDN_ST_DARK 1
`define ICDN_ST_PENDING 2

// Interrupt bits
`define ICDN_INT_TO_NIGHT 0
`define ICDN_INT_TO_DAY 1
`define ICDN_INT_CROSS 2
`define ICDN_INT_WIDTH 3

// Reset values
`define ICDN_RST_CTRL 32'h00000000
`define ICDN_RST_SWLEVEL 16'h0000
`define ICDN_RST_WAIT 16'h000a
`define ICDN_RST_INTMASK 3'h0

// Timing: one second at the system clock rate
`define ICDN_CLK_HZ 20000000
`define ICDN_SEC_S 1
`define ICDN_SEC_CYCLES (`ICDN_CLK_HZ * `ICDN_SEC_S)

`endif

/* verif/icdn_day_night_properties.sv */
// Port checker for the day/night controller
module icdn_day_night_chk (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Far side
    input wire [15:0] darkLevel,
    input wire [7:0] gpioOut,
    input wire [7:0] gpioOe,
    input wire filterNight,
    input wire irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Access phase and unmapped address decode
    wire acc = psel && penable;
    wire bad = paddr > 8'h18 || paddr[1:0] != 2'h0;
    wire rd = acc && !pwrite;

    a_ready_access: assert property (pready == acc)
        else $error("pready differs from access phase");
    a_mapped_ok: assert property (acc && !bad |-> !pslverr)
        else $error("error on a mapped register");
    a_unmapped_err: assert property (acc && bad |-> pslverr)
        else $error("no error on an unmapped address");
    a_state_read: assert property (rd && paddr == 8'h10 |-> prdata[0] == $past(filterNight))
        else $error("state read disagrees with filter");
    a_level_read: assert property (rd && paddr == 8'h0c && $past(darkLevel) == $past(darkLevel, 2)
        |-> prdata == {{16{$past(darkLevel[15])}}, $past(darkLevel)})
        else $error("darkness read is wrong");
    a_reset_day: assert property ($fell(rst) |-> !filterNight && gpioOe == 8'h00 && !irq)
        else $error("not in day state after reset");
    a_oe_onehot: assert property ($onehot0(gpioOe))
        else $error("more than one pin driven");
    a_out_in_oe: assert property ((gpioOut & ~gpioOe) == 8'h00)
        else $error("output high on undriven pin");
    a_ann_state: assert property (gpioOe != 8'h00 |-> (gpioOut != 8'h00) == filterNight)
        else $error("announce pin disagrees with filter");

    c_to_night: cover property ($rose(filterNight));
    c_irq: cover property ($rose(irq));
    c_err: cover property (acc && pslverr);
endmodule

bind icdn_day_night icdn_day_night_chk chk_u (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .darkLevel(darkLevel), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .filterNight(filterNight), .irq(irq));

/* verif/icdn_far_side.sv */
// Far-side model: light sensor and I/O pins of the controller
module icdn_far_side (
    // Clock
    input wire logic sys_clk,
    // Scene and pad stimulus
    input wire logic [15:0] sceneDark,
    input wire logic [7:0] padDrive,
    // Controller side
    output logic [15:0] darkLevel,
    output logic [7:0] gpioIn,
    input wire logic [7:0] gpioOut,
    input wire logic [7:0] gpioOe
);
    // Sensor reports the scene one edge late
    always @(posedge sys_clk) begin
        darkLevel <= sceneDark;
    end
    // Pad level: controller wins where it drives, else the pad is an input
    assign gpioIn = (gpioOe & gpioOut) | (~gpioOe & padDrive);
endmodule

/* verif/tb.sv */
// Self-checking bench for the day/night controller
`include "icdn_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SEC = 4;
    typedef struct {logic [31:0] ctrl; logic [7:0] pad; logic exp;} icdn_row_t;
    logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, filterNight, irq, rerr;
    logic [7:0] paddr, gpioIn, gpioOut, gpioOe, padDrive;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0] darkLevel, sceneDark;
    int miscompares, checkCount, n;
    icdn_row_t rows [4] = '{'{32'h1, 8'h00, 1'b1}, '{32'h203, 8'h04, 1'b1},
        '{32'h203, 8'hfb, 1'b0}, '{32'h2, 8'hff, 1'b0}};

    icdn_day_night #(.SEC_CYCLES(SEC)) dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .darkLevel(darkLevel), .gpioIn(gpioIn),
        .gpioOut(gpioOut), .gpioOe(gpioOe), .filterNight(filterNight), .irq(irq));
    icdn_far_side far_u (.sys_clk(sys_clk), .sceneDark(sceneDark), .padDrive(padDrive),
        .darkLevel(darkLevel), .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe));

    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; result kept in rdat and rerr
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k == 20) begin miscompares++; stop_test(); end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Bounded wait for the filter to reach a position
    task automatic wait_filter(input logic v, output int c);
        c = 0;
        while (filterNight !== v && c < 60) begin @(posedge sys_clk); c++; end
        if (c == 60) begin miscompares++; stop_test(); end
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; sceneDark = 16'hff00; padDrive = 8'h00;
        miscompares = 0; checkCount = 0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        // Reset state and an unmapped access
        apb(1'b0, `ICDN_OFF_CTRL, 32'h0); chk(rdat, 32'h0);
        apb(1'b0, `ICDN_OFF_WAIT, 32'h0); chk(rdat, 32'ha);
        apb(1'b0, 8'h1c, 32'h0); chk(rerr, 1'b1);
        chk(filterNight, 1'b0);
        $display("reset test done");
        // Forced and input modes, bright scene ignored
        foreach (rows[i]) begin
            padDrive <= rows[i].pad;
            apb(1'b1, `ICDN_OFF_CTRL, rows[i].ctrl);
            repeat (3) @(posedge sys_clk);
            chk(filterNight, rows[i].exp);
            apb(1'b0, `ICDN_OFF_STATE, 32'h0); chk(rdat[0], rows[i].exp);
        end
        $display("mode table done");
        // Auto mode, day to night with announce on port 5
        apb(1'b1, `ICDN_OFF_SWLEVEL, 32'h10);
        apb(1'b1, `ICDN_OFF_WAIT, 32'h1);
        apb(1'b1, `ICDN_OFF_INTMASK, 32'h1);
        // Forced moves left night and day events behind; the read clears them
        apb(1'b0, `ICDN_OFF_INTSTAT, 32'h0); chk(rdat, 32'h3);
        apb(1'b1, `ICDN_OFF_CTRL, 32'h5010);
        chk(irq, 1'b0);
        sceneDark <= 16'h0020;
        wait_filter(1'b1, n);
        chk(n >= SEC + 4 && n <= SEC + 6, 1'b1);
        chk(gpioOe, 8'h20); chk(gpioOut, 8'h20);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b1);
        apb(1'b0, `ICDN_OFF_CURLEVEL, 32'h0); chk(rdat, 32'h20);
        apb(1'b0, `ICDN_OFF_INTSTAT, 32'h0); chk(rdat, 32'h5);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b0);
        $display("day to night done");
        // Two short bright spells; together they would outlast the wait without restart
        repeat (2) begin
            sceneDark <= 16'hffd0;
            repeat (3) @(posedge sys_clk);
            sceneDark <= 16'h0020;
            repeat (3) @(posedge sys_clk);
        end
        repeat (3 * SEC) @(posedge sys_clk);
        chk(filterNight, 1'b1);
        // Night to day, masked event keeps irq low
        sceneDark <= 16'hffd0;
        wait_filter(1'b0, n);
        chk(n >= SEC + 4 && n <= SEC + 6, 1'b1);
        chk(gpioOut, 8'h00);
        apb(1'b0, `ICDN_OFF_CURLEVEL, 32'h0); chk(rdat, 32'hffffffd0);
        chk(irq, 1'b0);
        $display("night to day done");
        // Reset in mid-run while forced to night and announcing
        apb(1'b1, `ICDN_OFF_CTRL, 32'h5011);
        repeat (2) @(posedge sys_clk);
        chk(filterNight, 1'b1);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        chk(filterNight, 1'b0);
        chk(gpioOe, 8'h00);
        apb(1'b0, `ICDN_OFF_CTRL, 32'h0); chk(rdat, 32'h0);
        apb(1'b0, `ICDN_OFF_WAIT, 32'h0); chk(rdat, 32'ha);
        $display("mid-run reset done");
        stop_test();
    end
endmodule
